// ==== hw/ssp_pkg.sv ====
// ssp_pkg: constants for the synthesizer serial control port
// assumes: 24-bit control words with the latch address in the top three bits
package ssp_pkg;
	localparam int WORD_W = 24;
	localparam int ADDR_W = 3;
	localparam int FREQ_W = 22;
	localparam int DEV_W = 8;
	localparam int GAIN_W = 3;
	localparam int AMP_W = 2;

	// latch addresses
	localparam logic [2:0] ADDR_WORD_A = 3'h0;
	localparam logic [2:0] ADDR_WORD_B = 3'h1;
	localparam logic [2:0] ADDR_WORD_C = 3'h2;
	localparam logic [2:0] ADDR_WORD_D = 3'h3;
	localparam logic [2:0] ADDR_TEST = 3'h7;

	// field positions
	localparam int ADDR_LSB = 21;
	localparam int FREQ_LSB = 0;
	localparam int DEV_LSB = 13;
	localparam int GAIN_LSB = 18;
	localparam int DIV_BIT = 17;
	localparam int MODSEL_BIT = 16;
	localparam int SYNTH_EN_BIT = 12;
	localparam int OSC_EN_BIT = 11;
	localparam int AMP_LSB = 9;

	// reset values
	localparam logic [23:0] WORD_RESET = 24'h000000;
	localparam logic [23:0] TEST_CLEAR = 24'hE00000;
	localparam logic [1:0] AMP_OFF = 2'h0;
endpackage

// ==== hw/ssp_sync.sv ====
// ssp_sync: two-flop synchroniser, one per bit
// assumes: inputs are asynchronous pins; q is safe for any logic
`timescale 1ns/10ps
module ssp_sync
	import ssp_pkg::*;
#(
	parameter int W = 1
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	initial
	begin
		if (W < 1)
			$error("ssp_sync: width must be at least 1");
	end

	logic [W-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					meta[i] <= 1'b0;
					q[i] <= 1'b0;
				end
				else
				begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

// ==== hw/ssp_port.sv ====
// ssp_port: 3-wire write-only control port and its latches
// assumes: clk much faster than the serial clock; rst models power-up
//
// Function
// - shift data in on each serial clock rise while strobe is low
// - strobe rise loads word into addressed latch
// - only last twenty-four bits are kept
// - writes accepted in standby and active
// - 24-bit words, first bit is MSB
// - address 111 is the test latch
// - test mode held until cleared or reset
// - word C bit selects divide 256/512
// - word C three-bit acquisition gain field
// - acquisition pump only while loop unlocked
// - bank-0 amplifier level field, reset 00
// - bank-0 bit 11 enables oscillator
// - bank-0 bit 12 enables synthesizer chain
// - mode pin selects bank-0 or bank-1
// - standby low powers down, programming kept
// - word A holds bank-0 22-bit frequency
`timescale 1ns/10ps
module ssp_port
	import ssp_pkg::*;
#(
	parameter int SHIFT_W = WORD_W
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial pins
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_strobe,
	// control pins
	input wire logic mode_pin,
	input wire logic standby_n_pin,
	input wire logic pll_locked,
	// settings applied to the analog blocks
	output logic [FREQ_W-1:0] freq_setting,
	output logic [DEV_W-1:0] fsk_deviation,
	output logic [AMP_W-1:0] amp_level,
	output logic osc_enable,
	output logic synth_enable,
	output logic divider_ratio_select,
	output logic [GAIN_W-1:0] acquisition_gain,
	output logic modulation_select,
	output logic acquisition_pump_out,
	output logic test_mode
);
	initial
	begin
		if (SHIFT_W != WORD_W)
			$error("ssp_port: shift width must equal the word width");
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation and edge detection

	logic [4:0] pins_s;
	logic s_clk, s_data, s_strobe, s_mode, s_stby_n;
	logic s_clk_d, s_strobe_d;
	logic clk_rise, strobe_rise;

	ssp_sync #(.W(5)) u_sync
	(
		.clk(clk),
		.rst(rst),
		.d({ser_clk, ser_data, ser_strobe, mode_pin, standby_n_pin}),
		.q(pins_s)
	);

	assign {s_clk, s_data, s_strobe, s_mode, s_stby_n} = pins_s;

	logic s_locked;

	ssp_sync #(.W(1)) u_sync_lock
	(
		.clk(clk),
		.rst(rst),
		.d(pll_locked),
		.q(s_locked)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_clk_d <= 1'b0;
			s_strobe_d <= 1'b0;
		end
		else
		begin
			s_clk_d <= s_clk;
			s_strobe_d <= s_strobe;
		end
	end

	// clock edges under a high strobe are ignored
	assign clk_rise = s_clk & ~s_clk_d & ~s_strobe;
	assign strobe_rise = s_strobe & ~s_strobe_d;

	////////////////////////////////////////////////////////////////////////
	// shift register and latches

	logic [WORD_W-1:0] shreg, next_shreg;
	logic [WORD_W-1:0] word_a, word_b, word_c, bank0_control_word;
	logic [WORD_W-1:0] next_word_a, next_word_b, next_word_c;
	logic [WORD_W-1:0] next_bank0;
	logic next_test;
	logic [ADDR_W-1:0] addr;

	assign addr = shreg[ADDR_LSB +: ADDR_W];

	always_comb
	begin
		next_shreg = shreg;
		next_word_a = word_a;
		next_word_b = word_b;
		next_word_c = word_c;
		next_bank0 = bank0_control_word;
		next_test = test_mode;
		// older bits fall off the top
		if (clk_rise)
			next_shreg = {shreg[WORD_W-2:0], s_data};
		// loads happen regardless of standby
		if (strobe_rise)
		begin
			unique case (addr)
				ADDR_WORD_A: next_word_a = shreg;
				ADDR_WORD_B: next_word_b = shreg;
				ADDR_WORD_C: next_word_c = shreg;
				ADDR_WORD_D: next_bank0 = shreg;
				ADDR_TEST: next_test = (shreg != TEST_CLEAR);
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			shreg <= WORD_RESET;
			word_a <= WORD_RESET;
			word_b <= WORD_RESET;
			word_c <= WORD_RESET;
			bank0_control_word <= WORD_RESET;
			test_mode <= 1'b0;
		end
		else
		begin
			shreg <= next_shreg;
			word_a <= next_word_a;
			word_b <= next_word_b;
			word_c <= next_word_c;
			bank0_control_word <= next_bank0;
			test_mode <= next_test;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bank selection and registered outputs

	logic [WORD_W-1:0] bank_ctl, bank_freq;
	logic [FREQ_W-1:0] next_freq;
	logic [DEV_W-1:0] next_dev;
	logic [AMP_W-1:0] next_amp;
	logic next_osc, next_synth, next_div, next_modsel, next_pump;
	logic [GAIN_W-1:0] next_gain;

	always_comb
	begin
		// bank-1 enables share the C word layout
		bank_ctl = s_mode ? word_c : bank0_control_word;
		bank_freq = s_mode ? word_b : word_a;
		next_freq = bank_freq[FREQ_LSB +: FREQ_W];
		next_dev = bank0_control_word[DEV_LSB +: DEV_W];
		next_div = word_c[DIV_BIT];
		next_gain = word_c[GAIN_LSB +: GAIN_W];
		next_modsel = word_c[MODSEL_BIT];
		next_amp = AMP_OFF;
		next_osc = 1'b0;
		next_synth = 1'b0;
		// standby powers blocks down but keeps every latch
		if (s_stby_n)
		begin
			next_amp = bank_ctl[AMP_LSB +: AMP_W];
			next_osc = bank_ctl[OSC_EN_BIT];
			next_synth = bank_ctl[SYNTH_EN_BIT];
		end
		next_pump = next_synth & ~s_locked;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			freq_setting <= '0;
			fsk_deviation <= '0;
			amp_level <= AMP_OFF;
			osc_enable <= 1'b0;
			synth_enable <= 1'b0;
			divider_ratio_select <= 1'b0;
			acquisition_gain <= '0;
			modulation_select <= 1'b0;
			acquisition_pump_out <= 1'b0;
		end
		else
		begin
			freq_setting <= next_freq;
			fsk_deviation <= next_dev;
			amp_level <= next_amp;
			osc_enable <= next_osc;
			synth_enable <= next_synth;
			divider_ratio_select <= next_div;
			acquisition_gain <= next_gain;
			modulation_select <= next_modsel;
			acquisition_pump_out <= next_pump;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	property p_shift;
		@(posedge clk) disable iff (rst)
		clk_rise |=> shreg == {$past(shreg[WORD_W-2:0]), $past(s_data)};
	endproperty
	a_shift: assert property (p_shift)
		else $error("serial bit not shifted in at lsb");

	property p_hold_shift;
		@(posedge clk) disable iff (rst)
		!clk_rise |=> $stable(shreg);
	endproperty
	a_hold_shift: assert property (p_hold_shift)
		else $error("shift register changed without a clock edge");

	property p_load_d;
		@(posedge clk) disable iff (rst)
		strobe_rise && addr == ADDR_WORD_D |=>
			bank0_control_word == $past(shreg);
	endproperty
	a_load_d: assert property (p_load_d)
		else $error("bank-0 word not loaded on strobe");

	property p_load_a_standby;
		@(posedge clk) disable iff (rst)
		strobe_rise && addr == ADDR_WORD_A && !s_stby_n |=>
			word_a == $past(shreg);
	endproperty
	a_load_a_standby: assert property (p_load_a_standby)
		else $error("word A not loaded during standby");

	property p_test_set;
		@(posedge clk) disable iff (rst)
		strobe_rise && addr == ADDR_TEST && shreg != TEST_CLEAR
			|=> test_mode;
	endproperty
	a_test_set: assert property (p_test_set)
		else $error("test latch write did not enter test mode");

	property p_test_hold;
		@(posedge clk) disable iff (rst)
		test_mode && !(strobe_rise && shreg == TEST_CLEAR) |=> test_mode;
	endproperty
	a_test_hold: assert property (p_test_hold)
		else $error("test mode left without the clear pattern");

	property p_standby_off;
		@(posedge clk) disable iff (rst)
		!s_stby_n |=> amp_level == AMP_OFF && !osc_enable && !synth_enable;
	endproperty
	a_standby_off: assert property (p_standby_off)
		else $error("blocks powered during standby");

	property p_bank0_apply;
		@(posedge clk) disable iff (rst)
		s_stby_n && !s_mode |=>
			amp_level == $past(bank0_control_word[AMP_LSB +: AMP_W]) &&
			synth_enable == $past(bank0_control_word[SYNTH_EN_BIT]) &&
			osc_enable == $past(bank0_control_word[OSC_EN_BIT]);
	endproperty
	a_bank0_apply: assert property (p_bank0_apply)
		else $error("bank-0 enables not applied");

	property p_freq_sel;
		@(posedge clk) disable iff (rst)
		!s_mode |=> freq_setting == $past(word_a[FREQ_W-1:0]);
	endproperty
	a_freq_sel: assert property (p_freq_sel)
		else $error("bank-0 frequency not selected");

	property p_pump;
		@(posedge clk) disable iff (rst)
		s_locked |=> !acquisition_pump_out;
	endproperty
	a_pump: assert property (p_pump)
		else $error("acquisition pump on while locked");

	property p_div;
		@(posedge clk) disable iff (rst)
		1'b1 |=> divider_ratio_select == $past(word_c[DIV_BIT]) &&
			acquisition_gain == $past(word_c[GAIN_LSB +: GAIN_W]);
	endproperty
	a_div: assert property (p_div)
		else $error("word C fields not applied");

	c_load_d: cover property (@(posedge clk) disable iff (rst)
		strobe_rise && addr == ADDR_WORD_D);
	c_test_clear: cover property (@(posedge clk) disable iff (rst)
		test_mode ##1 !test_mode);
	c_mode1: cover property (@(posedge clk) disable iff (rst)
		s_mode && synth_enable);
	c_pump: cover property (@(posedge clk) disable iff (rst)
		acquisition_pump_out ##1 !acquisition_pump_out);
endmodule

// ==== verif/ssp_host_model.sv ====
// ssp_host_model: host side of the 3-wire control port
// assumes: clk is the bench clock; one serial bit spans 8 clk cycles
`timescale 1ns/10ps
module ssp_host_model
(
	// bench clock
	input wire logic clk,
	// serial pins
	output logic ser_clk,
	output logic ser_data,
	output logic ser_strobe
);
	initial
	begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_strobe = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// shift n bits msb first, then strobe with clock and data low
	task automatic send(input logic [31:0] b, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			ser_data = b[i];
			idle(4);
			ser_clk = 1'b1;
			// data flips while the clock is still high: only the rise samples
			idle(2);
			ser_data = ~b[i];
			idle(2);
			ser_clk = 1'b0;
		end
		idle(2);
		ser_data = 1'b0;
		idle(2);
		ser_strobe = 1'b1;
		idle(4);
		ser_strobe = 1'b0;
		idle(4);
	endtask
endmodule

// ==== verif/tb_ssp_port.sv ====
// tb_ssp_port: self-checking bench for the serial control port
// assumes: host model drives the serial pins; latches modelled here
`timescale 1ns/10ps
`define CHK(a, e) \
	begin \
		comparisons++; \
		if ((a) !== (e)) \
		begin \
			failures++; \
			$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
		end \
	end
module tb_ssp_port
	import ssp_pkg::*;
;
	logic clk = 1'b0;
	logic rst, ser_clk, ser_data, ser_strobe;
	logic mode_pin, standby_n_pin, pll_locked;
	logic [FREQ_W-1:0] freq_setting;
	logic [DEV_W-1:0] fsk_deviation;
	logic [AMP_W-1:0] amp_level;
	logic [GAIN_W-1:0] acquisition_gain;
	logic osc_enable, synth_enable, divider_ratio_select;
	logic modulation_select, acquisition_pump_out, test_mode;
	logic [23:0] lat [8];
	logic tst;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////
	ssp_port u_ssp_port
	(
		.clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_strobe(ser_strobe), .mode_pin(mode_pin),
		.standby_n_pin(standby_n_pin), .pll_locked(pll_locked),
		.freq_setting(freq_setting), .fsk_deviation(fsk_deviation),
		.amp_level(amp_level), .osc_enable(osc_enable),
		.synth_enable(synth_enable),
		.divider_ratio_select(divider_ratio_select),
		.acquisition_gain(acquisition_gain),
		.modulation_select(modulation_select),
		.acquisition_pump_out(acquisition_pump_out),
		.test_mode(test_mode)
	);
	ssp_host_model u_ssp_host_model
	(
		.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_strobe(ser_strobe)
	);
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			wrap_up();
		end
	end
	// random payload; modulation select kept at its legal 0
	function automatic logic [23:0] rnd(input logic [2:0] a);
		logic [23:0] r;
		r = 24'($urandom()) & 24'h1EFFFF;
		return {a, 21'h0} | r;
	endfunction
	task automatic check_all();
		logic [23:0] f, k;
		logic on;
		u_ssp_host_model.idle(8);
		f = mode_pin ? lat[ADDR_WORD_B] : lat[ADDR_WORD_A];
		k = mode_pin ? lat[ADDR_WORD_C] : lat[ADDR_WORD_D];
		on = standby_n_pin;
		`CHK(freq_setting, f[21:0])
		`CHK(fsk_deviation, lat[ADDR_WORD_D][20:13])
		`CHK(amp_level, on ? k[10:9] : AMP_OFF)
		`CHK(osc_enable, on & k[OSC_EN_BIT])
		`CHK(synth_enable, on & k[SYNTH_EN_BIT])
		`CHK(divider_ratio_select, lat[ADDR_WORD_C][DIV_BIT])
		`CHK(acquisition_gain, lat[ADDR_WORD_C][20:18])
		`CHK(modulation_select, lat[ADDR_WORD_C][MODSEL_BIT])
		`CHK(acquisition_pump_out, on & k[12] & ~pll_locked)
		`CHK(test_mode, tst)
	endtask
	// only the last 24 bits count; top three bits address the latch
	task automatic write(input logic [31:0] b, input int n = 24);
		logic [2:0] a;
		u_ssp_host_model.send(b, n);
		a = b[23:21];
		if (a <= ADDR_WORD_D)
			lat[a] = b[23:0];
		if (a == ADDR_TEST)
			tst = (b[20:0] != 21'h0);
		check_all();
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		mode_pin = 1'b0;
		standby_n_pin = 1'b1;
		pll_locked = 1'b0;
		tst = 1'b0;
		foreach (lat[i]) lat[i] = WORD_RESET;
		void'($urandom(16));
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check_all();
		write(TEST_CLEAR);
		for (int i = 0; i < 4; i++)
			write(rnd(i[2:0]));
		write(rnd(ADDR_WORD_D) | 24'h001800);
		for (int m = 0; m < 8; m++)
		begin
			mode_pin = m[0];
			standby_n_pin = m[1];
			pll_locked = m[2];
			check_all();
		end
		for (int p = 0; p < 4; p++)
			write({ADDR_WORD_D, 21'h001800} | (24'(p) << AMP_LSB));
		standby_n_pin = 1'b0;
		write(rnd(ADDR_WORD_C));
		write({8'hA5, rnd(ADDR_WORD_A)}, 32);
		for (int a = 4; a < 7; a++)
			write(rnd(a[2:0]));
		write(rnd(ADDR_TEST) | 24'h000001);
		write(rnd(ADDR_WORD_B));
		write(TEST_CLEAR);
		write(rnd(ADDR_TEST) | 24'h100000);
		rst = 1'b1;
		u_ssp_host_model.idle(2);
		rst = 1'b0;
		tst = 1'b0;
		foreach (lat[i]) lat[i] = WORD_RESET;
		check_all();
		wrap_up();
	end
endmodule
